/* File: design/bdx_consts.vh */
// constants for the branch and data transfer execution unit
// assumes inclusion by bare name from the design files
`ifndef BDX_CONSTS_VH
`define BDX_CONSTS_VH

// widths and reset values
`define BDX_PC_W 10
`define BDX_DM_AW 16
`define BDX_PC_RST 10'h000

// pointer pair selectors: pair base register is 24 + 2 * selector
`define BDX_PTR_X 2'h1
`define BDX_PTR_Y 2'h2
`define BDX_PTR_Z 2'h3
`define BDX_REG_ZERO 5'h00
`define BDX_REG_HIGH 1'h1

// status flag positions in the flag byte
`define BDX_FLAG_V 3'h3
`define BDX_FLAG_N 3'h2

// opcode prefixes
`define BDX_PFX_BR 5'h1e
`define BDX_PFX_MOV 6'h0b
`define BDX_PFX_LDI 4'he
`define BDX_PFX_GRP9 6'h24
`define BDX_PFX_OFFS 2'h2
`define BDX_OP_LPM_R0 16'h95c8

// addressing mode field of the pointer group
`define BDX_MD_ABS 4'h0
`define BDX_MD_ZINC 4'h1
`define BDX_MD_ZDEC 4'h2
`define BDX_MD_LPMZ 4'h4
`define BDX_MD_YINC 4'h9
`define BDX_MD_YDEC 4'ha
`define BDX_MD_X 4'hc
`define BDX_MD_XINC 4'hd
`define BDX_MD_XDEC 4'he

// pointer arithmetic deltas
`define BDX_DELTA_INC 16'h0001
`define BDX_DELTA_DEC 16'hffff

`endif

/* File: design/bdx_regfile.v */
// general purpose register file, 32 bytes, with a 16-bit pointer port
// assumes a single clock; writes are frozen while ce_i is low
`timescale 1ns/1ps
`default_nettype none
module bdx_regfile #(
	parameter DW = 8
) (
	// clock and enable
	input wire mclk_i,
	input wire ce_i,
	// byte read ports
	input wire [4:0] rd_addr_i,
	output wire [DW-1:0] rd_data_o,
	input wire [4:0] rr_addr_i,
	output wire [DW-1:0] rr_data_o,
	// pointer read port
	input wire [1:0] ptr_sel_i,
	output wire [2*DW-1:0] ptr_data_o,
	// byte write port
	input wire wb_en_i,
	input wire [4:0] wb_addr_i,
	input wire [DW-1:0] wb_data_i,
	// pointer write port
	input wire pw_en_i,
	input wire [1:0] pw_sel_i,
	input wire [2*DW-1:0] pw_data_i
);
	reg [DW-1:0] regs [0:31];
	wire [4:0] ptr_lo;
	wire [4:0] pw_lo;

	// pairs live in the top eight registers, low byte at the even index
	assign ptr_lo = {2'h3, ptr_sel_i, 1'b0};
	assign pw_lo = {2'h3, pw_sel_i, 1'b0};
	assign rd_data_o = regs[rd_addr_i];
	assign rr_data_o = regs[rr_addr_i];
	assign ptr_data_o = {regs[{ptr_lo[4:1], 1'b1}], regs[ptr_lo]};

	always @(posedge mclk_i) begin
		if (ce_i) begin
			if (wb_en_i) begin
				regs[wb_addr_i] <= wb_data_i;
			end
			if (pw_en_i) begin
				regs[pw_lo] <= pw_data_i[DW-1:0];
				regs[{pw_lo[4:1], 1'b1}] <= pw_data_i[2*DW-1:DW];
			end
		end
	end
endmodule // bdx_regfile
`default_nettype wire

/* File: design/bdx_core.v */
// execution unit for relative branches and data transfers
// assumes program and data memories on the same clock that answer
// combinationally to the registered addresses, and a flag byte driven by
// the arithmetic unit on the same clock
`include "bdx_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module bdx_core #(
	parameter PC_W = `BDX_PC_W,
	parameter DM_AW = `BDX_DM_AW
) (
	// clock, reset and enable
	input wire mclk_i,
	input wire sys_rst_i,
	input wire ce_i,
	// status flags, bit order I T H S V N Z C from 7 down to 0
	input wire [7:0] flags_i,
	// program memory: word at pm_addr_o low, following word high
	output wire [PC_W-1:0] pm_addr_o,
	input wire [31:0] pm_data_i,
	// data memory
	output wire [DM_AW-1:0] dm_addr_o,
	output wire [7:0] dm_wdata_o,
	output wire dm_we_o,
	output wire dm_re_o,
	input wire [7:0] dm_rdata_i,
	// status
	output wire [PC_W-1:0] pc_o,
	output wire unknown_op_o
);
	localparam [4:0] S_EXEC = 5'h01;
	localparam [4:0] S_FLUSH = 5'h02;
	localparam [4:0] S_MEM = 5'h04;
	localparam [4:0] S_LPM1 = 5'h08;
	localparam [4:0] S_LPM2 = 5'h10;

	function [15:0] bdx_add16;
		input [15:0] a;
		input [15:0] b;
		begin
			bdx_add16 = a + b;
		end
	endfunction

	// program counter arithmetic wraps at the counter width on purpose
	function [PC_W-1:0] bdx_pc_add;
		input [PC_W-1:0] a;
		input [PC_W-1:0] b;
		begin
			bdx_pc_add = a + b;
		end
	endfunction

	// registers
	reg [4:0] state_reg;
	reg [4:0] state_next;
	reg [PC_W-1:0] pc_reg;
	reg [PC_W-1:0] pc_next;
	reg [PC_W-1:0] pm_addr_reg;
	reg [PC_W-1:0] pm_addr_next;
	reg [DM_AW-1:0] dm_addr_reg;
	reg [DM_AW-1:0] dm_addr_next;
	reg [7:0] dm_wdata_reg;
	reg [7:0] dm_wdata_next;
	reg dm_we_reg;
	reg dm_we_next;
	reg dm_re_reg;
	reg dm_re_next;
	reg [4:0] dst_reg;
	reg [4:0] dst_next;
	reg lpm_hi_reg;
	reg lpm_hi_next;
	reg unk_reg;
	reg unk_next;

	// register file write controls
	reg wb_en;
	reg [4:0] wb_addr;
	reg [7:0] wb_data;
	reg pw_en;
	reg [15:0] pw_data;

	// decode
	wire [15:0] instr;
	wire [15:0] abs_word;
	wire [3:0] mode;
	wire [4:0] op_rd;
	wire [4:0] op_rr;
	wire [5:0] disp;
	wire is_br;
	wire flag_n;
	wire flag_v;
	wire sign_nv;
	wire [7:0] cond_vec;
	wire cond_bit;
	wire br_taken;
	wire is_mov;
	wire is_ldi;
	wire is_grp9;
	wire is_offs;
	wire is_lpm0;
	wire is_lpmz;
	wire is_lpm;
	wire is_ptr_mode;
	wire is_abs;
	wire is_mem;
	wire is_store;
	wire post_inc;
	wire pre_dec;
	wire [1:0] ptr_sel;
	wire [15:0] ptr_data;
	wire [15:0] ptr_inc;
	wire [15:0] ptr_dec;
	wire [15:0] ptr_disp;
	wire [15:0] mem_addr16;
	wire [7:0] rd_data;
	wire [7:0] rr_data;
	wire [PC_W-1:0] pc_inc;
	wire [PC_W-1:0] pc_inc2;
	wire [PC_W-1:0] br_offs;
	wire [PC_W-1:0] br_target;

	assign instr = pm_data_i[15:0];
	assign abs_word = pm_data_i[31:16];
	assign mode = instr[3:0];
	assign op_rd = instr[8:4];
	assign op_rr = {instr[9], instr[3:0]};
	assign disp = {instr[13], instr[11:10], instr[2:0]};

	// one status bit, chosen by the low three bits, against the polarity bit;
	// every named conditional branch is one of these two encodings
	assign is_br = (instr[15:11] == `BDX_PFX_BR);
	// the sign slot is rebuilt from N and V instead of trusting the S input,
	// so the signed compares hold even if S lags the other flags
	assign flag_n = flags_i[`BDX_FLAG_N];
	assign flag_v = flags_i[`BDX_FLAG_V];
	assign sign_nv = flag_n ^ flag_v;
	assign cond_vec = {flags_i[7:5], sign_nv, flags_i[3:0]};
	assign cond_bit = cond_vec[instr[2:0]];
	assign br_taken = cond_bit ^ instr[10];

	assign is_mov = (instr[15:10] == `BDX_PFX_MOV);
	assign is_ldi = (instr[15:12] == `BDX_PFX_LDI);
	assign is_grp9 = (instr[15:10] == `BDX_PFX_GRP9);
	// plain Y and Z access is the offset form with zero displacement
	assign is_offs = (instr[15:14] == `BDX_PFX_OFFS) && !instr[12];
	assign is_lpm0 = (instr == `BDX_OP_LPM_R0);
	assign is_lpmz = is_grp9 && !instr[9] && (mode == `BDX_MD_LPMZ);
	assign is_lpm = is_lpm0 || is_lpmz;
	assign is_abs = is_grp9 && (mode == `BDX_MD_ABS);
	assign is_ptr_mode = (mode == `BDX_MD_ZINC) || (mode == `BDX_MD_ZDEC) ||
		(mode == `BDX_MD_YINC) || (mode == `BDX_MD_YDEC) ||
		(mode == `BDX_MD_X) || (mode == `BDX_MD_XINC) ||
		(mode == `BDX_MD_XDEC);
	assign is_mem = is_offs || (is_grp9 && (is_abs || is_ptr_mode));
	assign is_store = instr[9];
	assign post_inc = is_grp9 && is_ptr_mode && (mode[1:0] == 2'h1);
	assign pre_dec = is_grp9 && is_ptr_mode && (mode[1:0] == 2'h2);

	assign ptr_sel = is_offs ? (instr[3] ? `BDX_PTR_Y : `BDX_PTR_Z) :
		is_lpm ? `BDX_PTR_Z :
		(mode[3:2] == 2'h3) ? `BDX_PTR_X :
		mode[3] ? `BDX_PTR_Y : `BDX_PTR_Z;

	// full 16-bit arithmetic so a carry crosses into the high byte
	assign ptr_inc = bdx_add16(ptr_data, `BDX_DELTA_INC);
	assign ptr_dec = bdx_add16(ptr_data, `BDX_DELTA_DEC);
	assign ptr_disp = bdx_add16(ptr_data, {10'h000, disp});

	assign mem_addr16 = is_abs ? abs_word :
		is_offs ? ptr_disp :
		pre_dec ? ptr_dec :
		ptr_data;

	assign pc_inc = bdx_pc_add(pc_reg, {{(PC_W-1){1'b0}}, 1'b1});
	assign pc_inc2 = bdx_pc_add(pc_reg, {{(PC_W-2){1'b0}}, 2'h2});
	assign br_offs = {{(PC_W-7){instr[9]}}, instr[9:3]};
	assign br_target = bdx_pc_add(pc_inc, br_offs);

	bdx_regfile #(
		.DW(8)
	) u_regs (
		.mclk_i(mclk_i),
		.ce_i(ce_i),
		.rd_addr_i(op_rd),
		.rd_data_o(rd_data),
		.rr_addr_i(op_rr),
		.rr_data_o(rr_data),
		.ptr_sel_i(ptr_sel),
		.ptr_data_o(ptr_data),
		.wb_en_i(wb_en),
		.wb_addr_i(wb_addr),
		.wb_data_i(wb_data),
		.pw_en_i(pw_en),
		.pw_sel_i(ptr_sel),
		.pw_data_i(pw_data)
	);

	always @* begin
		state_next = state_reg;
		pc_next = pc_reg;
		pm_addr_next = pm_addr_reg;
		dm_addr_next = dm_addr_reg;
		dm_wdata_next = dm_wdata_reg;
		dm_we_next = 1'b0;
		dm_re_next = 1'b0;
		dst_next = dst_reg;
		lpm_hi_next = lpm_hi_reg;
		unk_next = 1'b0;
		wb_en = 1'b0;
		wb_addr = dst_reg;
		wb_data = dm_rdata_i;
		pw_en = 1'b0;
		pw_data = ptr_inc;
		case (state_reg)
			S_EXEC: begin
				pc_next = pc_inc;
				pm_addr_next = pc_inc;
				if (is_br) begin
					// a taken branch spends its second clock refetching
					if (br_taken) begin
						pc_next = br_target;
						pm_addr_next = br_target;
						state_next = S_FLUSH;
					end
				end else if (is_mov) begin
					wb_en = 1'b1;
					wb_addr = op_rd;
					wb_data = rr_data;
				end else if (is_ldi) begin
					wb_en = 1'b1;
					wb_addr = {`BDX_REG_HIGH, instr[7:4]};
					wb_data = {instr[11:8], instr[3:0]};
				end else if (is_lpm) begin
					// Z holds a byte address; bit 0 picks the half of the word
					pm_addr_next = ptr_data[PC_W:1];
					lpm_hi_next = ptr_data[0];
					dst_next = is_lpm0 ? `BDX_REG_ZERO : op_rd;
					state_next = S_LPM1;
				end else if (is_mem) begin
					dm_addr_next = mem_addr16[DM_AW-1:0];
					dm_wdata_next = rd_data;
					dm_we_next = is_store;
					dm_re_next = !is_store;
					dst_next = op_rd;
					// pointer write-back lands while the access is under way
					pw_en = post_inc || pre_dec;
					pw_data = pre_dec ? ptr_dec : ptr_inc;
					if (is_abs) begin
						pc_next = pc_inc2;
						pm_addr_next = pc_inc2;
					end
					state_next = S_MEM;
				end else begin
					// anything outside these groups passes as a one-clock no-op
					unk_next = 1'b1;
				end
			end
			S_FLUSH: begin
				state_next = S_EXEC;
			end
			S_MEM: begin
				wb_en = dm_re_reg;
				state_next = S_EXEC;
			end
			S_LPM1: begin
				wb_en = 1'b1;
				wb_data = lpm_hi_reg ? pm_data_i[15:8] : pm_data_i[7:0];
				pm_addr_next = pc_reg;
				state_next = S_LPM2;
			end
			S_LPM2: begin
				// third clock: program memory is pointed back at the program
				state_next = S_EXEC;
			end
			default: begin
				state_next = S_EXEC;
				pm_addr_next = pc_reg;
			end
		endcase
		// a frozen cycle must not write the register file or a pointer
		if (!ce_i) begin
			wb_en = 1'b0;
			pw_en = 1'b0;
		end
	end

	always @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= S_EXEC;
			pc_reg <= `BDX_PC_RST;
			pm_addr_reg <= `BDX_PC_RST;
			dm_addr_reg <= {DM_AW{1'b0}};
			dm_wdata_reg <= 8'h00;
			dm_we_reg <= 1'b0;
			dm_re_reg <= 1'b0;
			dst_reg <= 5'h00;
			lpm_hi_reg <= 1'b0;
			unk_reg <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			pm_addr_reg <= pm_addr_next;
			dm_addr_reg <= dm_addr_next;
			dm_wdata_reg <= dm_wdata_next;
			dm_we_reg <= dm_we_next;
			dm_re_reg <= dm_re_next;
			dst_reg <= dst_next;
			lpm_hi_reg <= lpm_hi_next;
			unk_reg <= unk_next;
		end
	end

	assign pm_addr_o = pm_addr_reg;
	assign dm_addr_o = dm_addr_reg;
	assign dm_wdata_o = dm_wdata_reg;
	assign dm_we_o = dm_we_reg;
	assign dm_re_o = dm_re_reg;
	assign pc_o = pc_reg;
	assign unknown_op_o = unk_reg;
endmodule // bdx_core
`default_nettype wire

/* File: verification/bdx_mem_model.sv */
// program and data memory model facing the core
// assumes the core clock; reads answer at once, writes land at the edge
`timescale 1ns/1ps
`default_nettype none
module bdx_mem_model (
	// clock
	input wire logic mclk_i,
	// program memory
	input wire logic [9:0] pm_addr_i,
	output logic [31:0] pm_data_o,
	// data memory
	input wire logic [15:0] dm_addr_i,
	input wire logic [7:0] dm_wdata_i,
	input wire logic dm_we_i,
	input wire logic dm_re_i,
	output logic [7:0] dm_rdata_o
);
	logic [15:0] pm [0:1023];
	logic [7:0] dm [0:65535];
	// unread data shows the inverse so a stale sample cannot pass
	assign dm_rdata_o = dm_re_i ? dm[dm_addr_i] : ~dm[dm_addr_i];
	assign pm_data_o = {pm[pm_addr_i + 1'b1], pm[pm_addr_i]};
	always @(posedge mclk_i) if (dm_we_i) dm[dm_addr_i] <= dm_wdata_i;
endmodule // bdx_mem_model
`default_nettype wire

/* File: verification/bdx_core_checker.sv */
// assertions on the ports of the branch and data transfer core
// assumes binding to bdx_core; one clock, reset active high
`timescale 1ns/1ps
`default_nettype none
module bdx_core_checker #(
	parameter PC_W = 10,
	parameter DM_AW = 16
) (
	// clock, reset, enable
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// core ports
	input wire logic [7:0] flags_i,
	input wire logic [PC_W-1:0] pm_addr_o,
	input wire logic [31:0] pm_data_i,
	input wire logic [DM_AW-1:0] dm_addr_o,
	input wire logic [7:0] dm_wdata_o,
	input wire logic dm_we_o,
	input wire logic dm_re_o,
	input wire logic [7:0] dm_rdata_i,
	input wire logic [PC_W-1:0] pc_o,
	input wire logic unknown_op_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// an access starts from an enabled edge
	sequence s_start(sig);
		$rose(sig) && $past(ce_i);
	endsequence
	sequence s_jump;
		$past(ce_i) && pc_o - $past(pc_o) > 1;
	endsequence
	chk_we_pulse: assert property (dm_we_o && ce_i |=> !dm_we_o)
		else $error("write strobe longer than one cycle");
	chk_re_pulse: assert property (dm_re_o && ce_i |=> !dm_re_o)
		else $error("read strobe longer than one cycle");
	chk_one_access: assert property (!(dm_we_o && dm_re_o))
		else $error("read and write strobes together");
	chk_store_hold: assert property (dm_we_o && ce_i |=>
		$stable(dm_addr_o) && $stable(dm_wdata_o))
		else $error("store address or data moved too early");
	chk_load_hold: assert property (dm_re_o && ce_i |=>
		$stable(dm_addr_o)) else $error("load address moved too early");
	chk_store_step: assert property (s_start(dm_we_o) |->
		(pc_o - $past(pc_o)) inside {1, 2}) else $error("bad store step");
	chk_load_step: assert property (s_start(dm_re_o) |->
		(pc_o - $past(pc_o)) inside {1, 2}) else $error("bad load step");
	chk_jump_flush: assert property (s_jump |=> $stable(pc_o))
		else $error("no idle cycle after a jump");
endmodule // bdx_core_checker
bind bdx_core bdx_core_checker #(.PC_W(PC_W), .DM_AW(DM_AW)) chk_u (
	.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .flags_i(flags_i),
	.pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .dm_addr_o(dm_addr_o),
	.dm_wdata_o(dm_wdata_o), .dm_we_o(dm_we_o), .dm_re_o(dm_re_o),
	.dm_rdata_i(dm_rdata_i), .pc_o(pc_o), .unknown_op_o(unknown_op_o));
`default_nettype wire

/* File: verification/test_branch_and_data_transfer_exec.sv */
// bench: generated programs run against a reference model of the core
// assumes bdx_mem_model as memory; stores checked by value and cycle
`timescale 1ns/1ps
`default_nettype none
module test_branch_and_data_transfer_exec;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic ce_i = 1'b0;
	logic [7:0] flags_i = 8'h00;
	logic [31:0] pm_data_i;
	logic [9:0] pm_addr_o, pc_o;
	logic [15:0] dm_addr_o;
	logic [7:0] dm_wdata_o, dm_rdata_i;
	logic dm_we_o, dm_re_o, unknown_op_o;
	logic [7:0] rm [0:31];
	logic [7:0] dmm [0:65535];
	logic [39:0] exq [$];
	int bad_count = 0;
	int n_compared = 0;
	int pa, cyc, ecnt, unk_at, cend;
	bdx_core dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
		.flags_i(flags_i), .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i),
		.dm_addr_o(dm_addr_o), .dm_wdata_o(dm_wdata_o), .dm_we_o(dm_we_o),
		.dm_re_o(dm_re_o), .dm_rdata_i(dm_rdata_i), .pc_o(pc_o),
		.unknown_op_o(unknown_op_o));
	bdx_mem_model mem_u (.mclk_i(mclk_i), .pm_addr_i(pm_addr_o),
		.pm_data_o(pm_data_i), .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o),
		.dm_we_i(dm_we_o), .dm_re_i(dm_re_o), .dm_rdata_o(dm_rdata_i));
	initial forever #25 mclk_i = ~mclk_i;
	always @(posedge mclk_i) ce_i <= #2 ($urandom % 8) != 0;
	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (bad_count == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// edge count of enabled cycles, so a frozen cycle shifts nothing
	always @(posedge mclk_i) if (!sys_rst_i && ce_i) begin
		ecnt++;
		if (ecnt <= cend) check(unknown_op_o, ecnt == unk_at);
		if (dm_we_o) check({ecnt[15:0], dm_addr_o, dm_wdata_o},
			exq.size() ? exq.pop_front() : 40'h0);
	end
	task automatic emit(input logic [15:0] w, input int n);
		mem_u.pm[pa] = w;
		pa++;
		cyc += n;
	endtask
	task automatic load_constant(input int d, input int k);
		emit({4'he, k[7:4], d[3:0], k[3:0]}, 1);
		rm[d] = k[7:0];
	endtask
	task automatic xfer(input bit st, input int d, input logic [15:0] a);
		if (st) begin
			dmm[a] = rm[d];
			exq.push_back({cyc[15:0], a, rm[d]});
		end else rm[d] = dmm[a];
	endtask
	task automatic abs(input bit st, input int d, input int a);
		emit({6'h24, st, d[4:0], 4'h0}, 2);
		emit(a[15:0], 0);
		xfer(st, d, a[15:0]);
	endtask
	task automatic ptr(input bit st, input int d, input logic [3:0] md);
		int b;
		logic [15:0] p;
		b = md[3:2] == 2'h3 ? 26 : (md[3] ? 28 : 30);
		p = {rm[b + 1], rm[b]} - (md[1:0] == 2'h2);
		emit({6'h24, st, d[4:0], md}, 2);
		xfer(st, d, p);
		{rm[b + 1], rm[b]} = p + (md[1:0] == 2'h1);
	endtask
	task automatic offs(input bit st, input int d, input int y, input int q);
		emit({2'h2, q[5], 1'b0, q[4:3], st, d[4:0], y[0], q[2:0]}, 2);
		xfer(st, d, (y[0] ? {rm[29], rm[28]} : {rm[31], rm[30]}) + q[5:0]);
	endtask
	task automatic program_mem_read(input int d);
		logic [15:0] w;
		w = mem_u.pm[{rm[31], rm[30]} >> 1];
		emit(d ? {6'h24, 1'b0, d[4:0], 4'h4} : 16'h95c8, 3);
		rm[d] = rm[30][0] ? w[15:8] : w[7:0];
	endtask
	task automatic br(input int s, input bit clr);
		bit t;
		t = (s == 4 ? flags_i[2] ^ flags_i[3] : flags_i[s]) ^ clr;
		emit({5'h1e, clr, 7'h01, s[2:0]}, t ? 2 : 1);
		if (t) emit(16'hef0f, 0);
		else load_constant(16, 8'hff);
	endtask
	initial begin
		logic [27:0] mds;
		mds = 28'h129adec;
		void'($urandom(78717));
		for (int i = 0; i < 65536; i++) begin
			dmm[i] = $urandom;
			mem_u.dm[i] = dmm[i];
		end
		for (int run = 0; run < 4; run++) begin
			@(posedge mclk_i);
			#2 sys_rst_i = 1'b1;
			// odd runs flip all flags but N; S stays as it falls, the core
			// must take the signed test from N and V alone
			flags_i = run[0] ? flags_i ^ 8'hfb : $urandom;
			for (int i = 0; i < 1024; i++) mem_u.pm[i] = i < 512 ? 16'h0 : $urandom;
			pa = 0;
			cyc = 0;
			ecnt = 0;
			for (int s = 0; s < 16; s++) begin
				load_constant(16, s);
				br(s / 2, s[0]);
				abs(1, 16, 16'h0100 + s);
			end
			emit(16'hffff, 1);
			unk_at = cyc + 1;
			load_constant(26, 0);
			load_constant(27, $urandom_range(1, 255));
			load_constant(28, 0);
			load_constant(29, $urandom_range(1, 255));
			load_constant(30, $urandom);
			load_constant(31, $urandom_range(4, 7));
			load_constant(20, $urandom);
			reg_copy(5, 20);
			reg_copy(21, 5);
			abs(1, 21, 16'h02ff);
			for (int i = 0; i < 7; i++) begin
				load_constant(21, $urandom);
				ptr(1, 21, mds[4*i +: 4]);
				ptr(0, 18, mds[4*i +: 4]);
				abs(1, 18, 16'h0200 + i);
			end
			for (int y = 0; y < 2; y++) begin
				offs(1, 21, y, 6'h3f);
				offs(0, 19, y, $urandom);
				abs(1, 19, 16'h0210 + y);
			end
			abs(0, 22, $urandom);
			abs(1, 22, 16'h0220);
			program_mem_read(0);
			program_mem_read(23);
			abs(1, 0, 16'h0221);
			abs(1, 23, 16'h0222);
			for (int b = 26; b < 32; b++) abs(1, b, 16'h0230 + b);
			cend = cyc;
			repeat (12) @(posedge mclk_i);
			#2 sys_rst_i = 1'b0;
			for (int w = 0; w < 4000 && exq.size() > 0; w++) @(posedge mclk_i);
			if (exq.size() > 0) begin
				bad_count++;
				break;
			end
		end
		tally_and_finish;
	end
	task automatic reg_copy(input int d, input int r);
		emit({6'h0b, r[4], d[4:0], r[3:0]}, 1);
		rm[d] = rm[r];
	endtask
endmodule // test_branch_and_data_transfer_exec
`default_nettype wire
